// >>> cfg_mem_readout.sv
// Serial configuration memory read-out, cascade, standby and ready logic
`timescale 1ns/1ps
// Function
// (R1) Data pin three-state in loading, open-drain two-way in programming mode.
// (R2) Every clock pin edge advances address and bit counter, reading or programming; the code counts rising edges only.
// (R3) Protect inputs guard memory only in programming; ignored while loading.
// (R4) Mode high: active gate level clears address and bit counters.
// (R5) Gate inactive and chip select low enable the data driver.
// (R6) Gate polarity chosen by stored setting; clear-on-low recommended.
// (R7) Block-protect high blocks writes to lowest block in programming with select low.
// (R8) Select low and gate enabled: clock advances counter, data driven.
// (R9) Select high stops counters and enters standby.
// (R10) In programming mode chip select has no enabling effect.
// (R11) Cascade output goes low when address counter reaches its maximum.
// (R12) Cascade low while enabled, then follows select until gate drops, then high.
// (R13) System chains each cascade output to the next chip select.
// (R14) Part select input selects device only in programming mode.
// (R15) Ready held low during power-up reset, then released.
// (R16) System holds mode input high for loading, low for programming.
// (R17) FPGA drives the clock pin and takes the data output.
// (R18) Address counter clears at power-up automatically.
// (R19) After all data out and cascade low, data pin released.
// (R20) Data output shows addressed bit, updated after each counting edge.
module cfg_mem_readout #(
  parameter int unsigned ADDR_W     = cfg_mem_pkg::ADDR_W_DEF,
  parameter int unsigned FIFO_W     = cfg_mem_pkg::FIFO_W_DEF,
  parameter int unsigned FIFO_D     = cfg_mem_pkg::FIFO_D_DEF,
  parameter int unsigned POR_CYCLES = cfg_mem_pkg::POR_CYCLES_DEF
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  // FPGA link pins
  input  wire logic              fpga_config_clock_i,
  input  wire logic              data_i,
  output logic                   data_o,
  output logic                   data_oe_o,
  input  wire logic              gate_i,
  input  wire logic              chip_sel_n_i,
  output logic                   cascade_enable_out_n_o,
  // Programming-mode pins
  input  wire logic              program_mode_select_n_i,
  input  wire logic              protect_in_one_i,
  input  wire logic              protect_in_two_i,
  input  wire logic              protect_block_i,
  input  wire logic              part_select_bit_i,
  // Stored configuration setting
  input  wire logic              clear_on_low_i,
  // Memory array fill path (words, low bit first)
  input  wire logic              fill_valid_i,
  output logic                   fill_ready_o,
  input  wire logic [FIFO_W-1:0] fill_data_i,
  // Status
  output logic                   ready_o,
  output logic                   ready_oe_o,
  output logic                   standby_o,
  output logic                   write_allowed_o,
  output logic                   low_block_locked_o,
  output logic [ADDR_W-1:0]      address_o
);
  localparam int unsigned BW     = $clog2(FIFO_W);
  localparam int unsigned POR_W  = $clog2(POR_CYCLES + 1);
  localparam int unsigned NPINS  = 8;

  // Two-flop synchronisers for every pin input
  logic [NPINS-1:0] pin_raw;
  logic [NPINS-1:0] sync1_reg;
  logic [NPINS-1:0] sync2_reg;
  cfg_mem_pkg::ctrl_pins_s pins;
  logic             data_in_s;

  assign pin_raw = {fpga_config_clock_i, gate_i, chip_sel_n_i, program_mode_select_n_i,
                    protect_in_one_i, protect_in_two_i, part_select_bit_i, data_i};
  assign pins      = sync2_reg[NPINS-1:1];
  assign data_in_s = sync2_reg[0];

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
    end
  end

  // Stored polarity, resampled every cycle after reset release
  logic clr_low_reg;
  logic blk_sync1_reg;
  logic blk_sync2_reg;
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      clr_low_reg   <= cfg_mem_pkg::CLR_LOW_DEF;
      blk_sync1_reg <= 1'b0;
      blk_sync2_reg <= 1'b0;
    end else begin
      clr_low_reg   <= clear_on_low_i;  // [R6]
      blk_sync1_reg <= protect_block_i;
      blk_sync2_reg <= blk_sync1_reg;
    end
  end

  // Power-up reset cycle
  logic [POR_W-1:0] por_cnt_reg;
  logic             por_done;
  assign por_done = (por_cnt_reg == POR_W'(POR_CYCLES));
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      por_cnt_reg <= '0;
    end else if (!por_done) begin
      por_cnt_reg <= por_cnt_reg + POR_W'(1);
    end
  end

  // Mode and gate decode
  logic loading;
  logic gate_clear;
  logic gate_enable;
  logic clk_rise;
  logic clk_prev_reg;
  logic enabled;
  logic at_max;
  logic count_en;
  logic advance;
  logic step_en;
  logic last_edge;
  logic done_reg;

  assign loading     = pins.mode_n;
  assign gate_clear  = (pins.gate ^ clr_low_reg) == 1'b0 ? 1'b0 : 1'b1;
  assign gate_enable = !gate_clear;
  assign clk_rise    = pins.clk_pin && !clk_prev_reg;
  // In programming the select pin is ignored; the part select enables instead
  assign enabled     = loading ? (!pins.chip_sel_n && gate_enable)  // [R8] [R9] [R5]
                               : pins.part_sel;                     // [R10] [R14]
  assign count_en    = por_done && enabled && clk_rise;  // [R2]
  // Once the end is reached in loading, further clocks are ignored until a clear
  assign advance     = count_en && !(loading && done_reg);
  // The edge that ends the last bit does not wrap the address; it ends the read
  assign step_en     = advance && !(loading && at_max);  // [R2]
  assign last_edge   = loading && advance && at_max;  // [R11]

  // Memory array bit counter and address counter
  logic [BW-1:0]     bit_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic              word_end;
  assign at_max   = (addr_reg == '1) && (bit_reg == BW'(FIFO_W - 1));
  assign word_end = (bit_reg == BW'(FIFO_W - 1));

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      clk_prev_reg <= 1'b0;
    end else begin
      clk_prev_reg <= pins.clk_pin;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i || !por_done) begin
      bit_reg  <= '0;  // [R18]
      addr_reg <= '0;  // [R18]
    end else if (loading && gate_clear) begin
      bit_reg  <= '0;  // [R4]
      addr_reg <= '0;  // [R4]
    end else if (step_en) begin
      bit_reg  <= word_end ? '0 : bit_reg + BW'(1);  // [R2]
      addr_reg <= word_end ? addr_reg + ADDR_W'(1) : addr_reg;  // [R2]
    end
  end

  // Data words arrive through the FIFO; each word boundary counted in loading pops one
  logic              fifo_valid;
  logic [FIFO_W-1:0] fifo_data;
  logic              fifo_pop;
  logic [FIFO_W-1:0] shift_reg;
  logic              shift_full_reg;
  assign fifo_pop = fifo_valid && (!shift_full_reg || (advance && word_end && loading));

  cfg_word_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_D)
  ) u_fifo (
    .clk_i        (clk_i),
    .rstn_i       (rstn_i),
    .in_valid_i   (fill_valid_i),
    .in_ready_o   (fill_ready_o),
    .in_data_i    (fill_data_i),
    .out_valid_o  (fifo_valid),
    .out_ready_i  (fifo_pop),
    .out_data_o   (fifo_data),
    .flush_done_o ()
  );

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      shift_reg      <= '0;
      shift_full_reg <= 1'b0;
    end else if (fifo_pop) begin
      shift_reg      <= fifo_data;
      shift_full_reg <= 1'b1;
    end else if (advance && loading) begin
      shift_reg      <= shift_reg >> 1;  // [R20]
      shift_full_reg <= word_end ? 1'b0 : shift_full_reg;
    end
  end

  // Cascade output: low at end of memory, then follows select until gate drops
  logic casc_reg;
  logic casc_next;
  always_comb begin
    casc_next = casc_reg;
    if (!loading || gate_clear) begin
      casc_next = 1'b1;  // [R12]
    end else if (done_reg) begin
      casc_next = pins.chip_sel_n;  // [R12]
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      done_reg <= 1'b0;
      casc_reg <= 1'b1;
    end else begin
      if (loading && gate_clear) begin
        done_reg <= 1'b0;
      end else if (last_edge) begin
        done_reg <= 1'b1;  // [R11]
      end
      casc_reg <= last_edge ? 1'b0 : casc_next;  // [R11]
    end
  end

  // Pin drivers
  logic drive_reg;
  logic dout_reg;
  logic rdy_oe_reg;
  logic stby_reg;
  logic wr_ok_reg;
  logic lock_reg;
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      drive_reg  <= 1'b0;
      dout_reg   <= 1'b0;
      rdy_oe_reg <= 1'b1;
      stby_reg   <= 1'b0;
      wr_ok_reg  <= 1'b0;
      lock_reg   <= 1'b0;
    end else begin
      if (loading) begin
        drive_reg <= por_done && enabled && !done_reg;  // [R1] [R5] [R19]
        dout_reg  <= shift_reg[0];  // [R20]
      end else begin
        drive_reg <= pins.part_sel && !data_in_s;  // [R1]
        dout_reg  <= 1'b0;
      end
      rdy_oe_reg <= !por_done;  // [R15]
      stby_reg   <= loading && pins.chip_sel_n;  // [R9]
      wr_ok_reg  <= !loading && pins.part_sel && !pins.protect_one && !pins.protect_two;  // [R3]
      lock_reg   <= !loading && !pins.chip_sel_n && blk_sync2_reg;  // [R7]
    end
  end

  assign data_o                 = dout_reg;
  assign data_oe_o              = drive_reg;
  assign cascade_enable_out_n_o = casc_reg;
  assign ready_o                = 1'b0;
  assign ready_oe_o             = rdy_oe_reg;
  assign standby_o              = stby_reg;
  assign write_allowed_o        = wr_ok_reg;
  assign low_block_locked_o     = lock_reg;
  assign address_o              = addr_reg;

  // Checks
  property p_clear_counters;
    @(posedge clk_i) disable iff (!rstn_i)
      (loading && gate_clear) |=> (addr_reg == '0 && bit_reg == '0);
  endproperty
  a_clear_counters: assert property (p_clear_counters) else $error("counter not cleared"); // [R4]

  property p_standby_hold;
    @(posedge clk_i) disable iff (!rstn_i)
      (loading && pins.chip_sel_n && !gate_clear) |=> $stable(addr_reg);
  endproperty
  a_standby_hold: assert property (p_standby_hold) else $error("counter moved in standby"); // [R9]

  property p_drive_needs_select;
    @(posedge clk_i) disable iff (!rstn_i)
      (loading && pins.chip_sel_n) |=> !data_oe_o;
  endproperty
  a_drive_needs_select: assert property (p_drive_needs_select) else $error("driven in standby"); // [R5]

  property p_ready_released;
    @(posedge clk_i) disable iff (!rstn_i)
      por_done |=> !ready_oe_o;
  endproperty
  a_ready_released: assert property (p_ready_released) else $error("ready not released"); // [R15]

  property p_done_release;
    @(posedge clk_i) disable iff (!rstn_i)
      (loading && done_reg) |=> !data_oe_o;
  endproperty
  a_done_release: assert property (p_done_release) else $error("data driven after end"); // [R19]

  property p_cascade_low;
    @(posedge clk_i) disable iff (!rstn_i)
      last_edge |=> !cascade_enable_out_n_o;
  endproperty
  a_cascade_low: assert property (p_cascade_low) else $error("cascade not low at end"); // [R11]

  property p_cascade_gate;
    @(posedge clk_i) disable iff (!rstn_i)
      (loading && gate_clear) |=> cascade_enable_out_n_o;
  endproperty
  a_cascade_gate: assert property (p_cascade_gate) else $error("cascade low after gate"); // [R12]

  sequence s_count_edge;
    step_en && word_end;
  endsequence
  property p_count_step;
    @(posedge clk_i) disable iff (!rstn_i)
      (s_count_edge and !(loading && gate_clear)) |=> (addr_reg == $past(addr_reg) + ADDR_W'(1));
  endproperty
  a_count_step: assert property (p_count_step) else $error("address did not advance"); // [R2]

  property p_protect_ignored;
    @(posedge clk_i) disable iff (!rstn_i)
      loading |=> !write_allowed_o && !low_block_locked_o;
  endproperty
  a_protect_ignored: assert property (p_protect_ignored) else $error("protect active in load"); // [R3]

  sequence s_end_reached;
    loading && done_reg && !gate_clear;
  endsequence
  property p_cascade_follow;
    @(posedge clk_i) disable iff (!rstn_i)
      s_end_reached |=> (cascade_enable_out_n_o == $past(pins.chip_sel_n));
  endproperty
  a_cascade_follow: assert property (p_cascade_follow) else $error("cascade stale"); // [R12]

  property p_end_hold;
    @(posedge clk_i) disable iff (!rstn_i)
      s_end_reached |=> $stable(addr_reg);
  endproperty
  a_end_hold: assert property (p_end_hold) else $error("address moved after end"); // [R11]

  property p_ready_held;
    @(posedge clk_i) disable iff (!rstn_i)
      !por_done |=> ready_oe_o;
  endproperty
  a_ready_held: assert property (p_ready_held) else $error("ready released early"); // [R15]

  property p_prog_no_standby;
    @(posedge clk_i) disable iff (!rstn_i)
      !loading |=> !standby_o;
  endproperty
  a_prog_no_standby: assert property (p_prog_no_standby) else $error("standby in program"); // [R10]
endmodule

// >>> cfg_mem_pkg.sv
// Shared constants and carrier types for the serial configuration memory read-out
package cfg_mem_pkg;
  localparam int unsigned ADDR_W_DEF      = 16;
  localparam int unsigned FIFO_W_DEF      = 8;
  localparam int unsigned FIFO_D_DEF      = 32;
  localparam int unsigned POR_CYCLES_DEF  = 16;
  localparam logic        CLR_LOW_DEF     = 1'b1;
  localparam int unsigned SYNC_STAGES     = 2;

  // Two-way pin carrier: output and output enable
  typedef struct packed {
    logic o;
    logic oe;
  } pin_drive_s;

  // Synchronised control pins
  typedef struct packed {
    logic clk_pin;
    logic gate;
    logic chip_sel_n;
    logic mode_n;
    logic protect_one;
    logic protect_two;
    logic part_sel;
  } ctrl_pins_s;
endpackage

// >>> cfg_word_fifo.sv
// Word FIFO with valid/ready on both sides
`timescale 1ns/1ps
module cfg_word_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rstn_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o,
  // Status
  output logic                  flush_done_o
);
  localparam int unsigned PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0]    wr_reg;
  logic [PW-1:0]    rd_reg;
  logic [PW:0]      cnt_reg;
  logic             push;
  logic             pop;

  assign in_ready_o   = (cnt_reg != (PW+1)'(DEPTH));
  assign out_valid_o  = (cnt_reg != '0);
  assign out_data_o   = mem_reg[rd_reg];
  assign push         = in_valid_i && in_ready_o;
  assign pop          = out_valid_o && out_ready_i;
  assign flush_done_o = (cnt_reg == '0);

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == PW'(DEPTH - 1)) ? '0 : wr_reg + PW'(1);
      end
      if (pop) begin
        rd_reg <= (rd_reg == PW'(DEPTH - 1)) ? '0 : rd_reg + PW'(1);
      end
      cnt_reg <= cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule

// >>> cfg_fpga_master.sv
// Master FPGA model: makes the config clock, drives gate and select, takes data
`timescale 1ns/1ps
module cfg_fpga_master (
  // Clock
  input  wire logic clk_i,
  // Data pin as resolved on the board
  input  wire logic data_pin_i,
  // Pins driven towards the memory
  output logic      fpga_config_clock_o,
  output logic      gate_o,
  output logic      chip_sel_n_o
);
  localparam int HALF = 4;

  // Config clock stands low between frames
  initial begin
    fpga_config_clock_o = 1'b0;
    gate_o = 1'b0;
    chip_sel_n_o = 1'b1;
  end

  task automatic set_pins(input logic gate, input logic sel_n);
    @(negedge clk_i);
    gate_o = gate;
    chip_sel_n_o = sel_n;
    repeat (6) @(negedge clk_i);
  endtask

  // Take each bit at the end of the low phase, then raise the clock
  task automatic shift(input int n, output logic [31:0] bits);
    bits = '0;
    for (int i = 0; i < n; i++) begin
      repeat (HALF) @(negedge clk_i);
      bits[i] = data_pin_i;
      fpga_config_clock_o = 1'b1;
      repeat (HALF) @(negedge clk_i);
      fpga_config_clock_o = 1'b0;
    end
  endtask
endmodule

// >>> tb_cfg_mem_readout.sv
// Self-checking testbench of the configuration memory read-out
`timescale 1ns/1ps
module tb_cfg_mem_readout;
  localparam int unsigned AW   = 2;
  localparam int unsigned PORC = 4;

  logic          clk_i;
  logic          rstn_i;
  logic          fpga_config_clock;
  logic          gate;
  logic          sel_n;
  logic          mode_n;
  logic          prot1;
  logic          prot2;
  logic          pblock;
  logic          psel;
  logic          clr_low;
  logic          fill_valid;
  logic [7:0]    fill_data;
  logic          fill_ready;
  logic          data_o;
  logic          data_oe_o;
  logic          casc_n;
  logic          ready_o;
  logic          ready_oe;
  logic          standby;
  logic          wr_ok;
  logic          locked;
  logic [AW-1:0] addr;
  int            fails;
  int            n_tests;
  int            k;

  // Data line has a pull-up on the FPGA side
  wire data_pin = data_oe_o ? data_o : 1'b1;
  // Chip select of a following memory in a chain
  wire next_sel_n = casc_n;

  cfg_mem_readout #(.ADDR_W(AW), .FIFO_W(8), .FIFO_D(32), .POR_CYCLES(PORC)) cfg_mem_readout_i (
    .clk_i                  (clk_i),
    .rstn_i                 (rstn_i),
    .fpga_config_clock_i    (fpga_config_clock),
    .data_i                 (data_pin),
    .data_o                 (data_o),
    .data_oe_o              (data_oe_o),
    .gate_i                 (gate),
    .chip_sel_n_i           (sel_n),
    .cascade_enable_out_n_o (casc_n),
    .program_mode_select_n_i(mode_n),
    .protect_in_one_i       (prot1),
    .protect_in_two_i       (prot2),
    .protect_block_i        (pblock),
    .part_select_bit_i      (psel),
    .clear_on_low_i         (clr_low),
    .fill_valid_i           (fill_valid),
    .fill_ready_o           (fill_ready),
    .fill_data_i            (fill_data),
    .ready_o                (ready_o),
    .ready_oe_o             (ready_oe),
    .standby_o              (standby),
    .write_allowed_o        (wr_ok),
    .low_block_locked_o     (locked),
    .address_o              (addr)
  );

  cfg_fpga_master cfg_fpga_master_i (
    .clk_i       (clk_i),
    .data_pin_i  (data_pin),
    .fpga_config_clock_o      (fpga_config_clock),
    .gate_o      (gate),
    .chip_sel_n_o(sel_n)
  );

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  function automatic logic [7:0] word(input int n);
    return 8'(n * 37) + 8'h5a;
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize;
    if (fails == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic settle;
    repeat (6) @(negedge clk_i);
  endtask

  // One full read of the four-word array, low bit first
  task automatic read_pass(input int base);
    logic [31:0] b;
    for (int w = 0; w < 4; w++) begin
      if (w == 3) check("cascade_early", casc_n, 1);
      cfg_fpga_master_i.shift(8, b);
      check("data_word", b[7:0], word(base + w));
      check("address", addr, (w < 3) ? w + 1 : 3);
    end
    settle();
    check("cascade_end", casc_n, 0);
    check("data_oe_end", data_oe_o, 0);
    check("next_select", next_sel_n, 0);
  endtask

  initial begin
    logic [31:0] b;
    rstn_i = 1'b0;
    mode_n = 1'b1; // Loading mode held high
    prot1 = 1'b0;
    prot2 = 1'b0;
    pblock = 1'b0;
    psel = 1'b0;
    clr_low = 1'b1;
    fill_valid = 1'b0;
    fill_data = 8'h00;
    fails = 0;
    n_tests = 0;
    k = 0;
    repeat (12) @(negedge clk_i);
    check("ready_oe_rst", ready_oe, 1);
    check("data_oe_rst", data_oe_o, 0);
    check("cascade_rst", casc_n, 1);
    check("address_rst", addr, 0);
    check("ready_level", ready_o, 0);
    rstn_i = 1'b1;
    @(negedge clk_i);
    check("ready_oe_por", ready_oe, 1);
    // Fill the buffer until it refuses
    fill_valid = 1'b1;
    repeat (40) begin
      fill_data = word(k);
      // Ready is settled at the falling edge and holds until the push edge
      if (fill_ready === 1'b1) k++;
      @(negedge clk_i);
    end
    fill_valid = 1'b0;
    check("fill_full", fill_ready, 0);
    check("fill_count", k >= 32, 1);
    check("ready_oe_done", ready_oe, 0);
    // Gate enabling but select high: standby, no counting
    cfg_fpga_master_i.set_pins(1'b1, 1'b1);
    check("standby", standby, 1);
    cfg_fpga_master_i.shift(3, b);
    check("address_standby", addr, 0);
    check("data_oe_standby", data_oe_o, 0);
    cfg_fpga_master_i.set_pins(1'b1, 1'b0);
    check("data_oe_on", data_oe_o, 1);
    read_pass(0);
    cfg_fpga_master_i.shift(2, b);
    check("address_held", addr, 3);
    cfg_fpga_master_i.set_pins(1'b1, 1'b1);
    check("cascade_follow_hi", casc_n, 1);
    cfg_fpga_master_i.set_pins(1'b1, 1'b0);
    check("cascade_follow_lo", casc_n, 0);
    cfg_fpga_master_i.set_pins(1'b0, 1'b0);
    check("cascade_cleared", casc_n, 1);
    check("address_cleared", addr, 0);
    cfg_fpga_master_i.set_pins(1'b1, 1'b0);
    check("cascade_stays", casc_n, 1);
    read_pass(4);
    // Reverse polarity: high clears, low enables
    clr_low = 1'b0;
    cfg_fpga_master_i.set_pins(1'b1, 1'b0);
    check("address_clr_high", addr, 0);
    check("data_oe_clr_high", data_oe_o, 0);
    cfg_fpga_master_i.set_pins(1'b0, 1'b0);
    read_pass(8);
    // Programming mode
    mode_n = 1'b0;
    psel = 1'b1;
    cfg_fpga_master_i.set_pins(1'b0, 1'b1);
    check("standby_prog", standby, 0);
    check("write_ok", wr_ok, 1);
    psel = 1'b0;
    settle();
    check("write_unselected", wr_ok, 0);
    psel = 1'b1;
    prot1 = 1'b1;
    settle();
    check("write_protect_one", wr_ok, 0);
    prot1 = 1'b0;
    prot2 = 1'b1;
    settle();
    check("write_protect_two", wr_ok, 0);
    prot2 = 1'b0;
    pblock = 1'b1;
    settle();
    check("locked_sel_high", locked, 0);
    cfg_fpga_master_i.set_pins(1'b0, 1'b0);
    check("locked_sel_low", locked, 1);
    pblock = 1'b0;
    settle();
    check("unlocked", locked, 0);
    mode_n = 1'b1;
    settle();
    check("write_loading", wr_ok, 0);
    summarize();
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    summarize();
  end
endmodule
